// ===== prc_params.svh
// Constants for the peripheral soft reset control block.
// Assumes inclusion by the package, the design module and the testbench.
`ifndef PRC_PARAMS_SVH
`define PRC_PARAMS_SVH

// ==========================================================
// Register byte offsets
`define PRC_OFS_CTRL0     12'h040
`define PRC_OFS_CTRL1     12'h044
`define PRC_ADDR_W        12

// ==========================================================
// Reset values and implemented bits
`define PRC_RST_VAL       32'h0000_0000
`define PRC_IMPL0         32'h0001_0048
`define PRC_IMPL1         32'h030F_5033

// ==========================================================
// Field positions, first register
`define PRC_B_ADC0        16
`define PRC_B_HIBERNATE   6
`define PRC_B_WATCHDOG    3
// Field positions, second register
`define PRC_B_CMP1        25
`define PRC_B_CMP0        24
`define PRC_B_TMR_HI      19
`define PRC_B_TMR_LO      16
`define PRC_B_TW1         14
`define PRC_B_TW0         12
`define PRC_B_SS1         5
`define PRC_B_SS0         4
`define PRC_B_AS1         1
`define PRC_B_AS0         0

// ==========================================================
// Bus responses
`define PRC_RESP_OKAY     2'h0
`define PRC_RESP_SLVERR   2'h2

`endif

// ===== prc_pkg.sv
// Types for the peripheral soft reset control block.
// Assumes prc_params.svh is on the include path.
`default_nettype none
`include "prc_params.svh"

package prc_pkg;

	typedef struct packed {
		logic        adc0;
		logic        hibernation;
		logic        watchdog;
		logic [1:0]  comparator;
		logic [3:0]  gp_counter;
		logic [1:0]  two_wire;
		logic [1:0]  sync_serial;
		logic [1:0]  async_serial;
	} prc_resets_t;

	typedef enum logic [1:0] {
		PRC_W_IDLE,
		PRC_W_RESP
	} prc_wstate_t;

endpackage

`default_nettype wire

// ===== prc_soft_reset.sv
// Software reset control registers with per-peripheral reset outputs.
// Assumes an AXI4-Lite master on clk and capability masks held stable by
// the system control logic around this block.
`timescale 1ns/1ps
`default_nettype none

`include "prc_params.svh"

// Contract
// - First register writes masked by first capability
// - Second register writes masked by second capability
// - Bit 16 resets converter 0
// - Bit 6 resets hibernation module
// - Bit 3 resets watchdog
// - Bits 25/24 reset comparators 1/0
// - Bits 19..16 reset counters 3..0
// - Bits 14/12 reset two-wire units 1/0
// - Bits 5/4 reset sync serial 1/0
// - Bits 1/0 reset async serial 1/0
// - Unassigned bits read zero, ignore writes
// - Both registers clear on system reset
module prc_soft_reset (
	input  wire logic                 clk,
	input  wire logic                 sys_rst,
	input  wire logic [31:0]          capability_mask_first,
	input  wire logic [31:0]          capability_mask_second,
	input  wire logic [11:0]          s_axi_awaddr,
	input  wire logic [2:0]           s_axi_awprot,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [11:0]          s_axi_araddr,
	input  wire logic [2:0]           s_axi_arprot,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	output prc_pkg::prc_resets_t      periph_reset
);
	import prc_pkg::*;

	// ==========================================================
	// Helpers
	function automatic logic [31:0] strb_mask(input logic [3:0] s);
		strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction

	function automatic logic [31:0] merge_write(input logic [31:0] old, input logic [31:0] wd,
	                                            input logic [31:0] en);
		merge_write = (old & ~en) | (wd & en);
	endfunction

	// ==========================================================
	// State
	logic [31:0]  ctrl0;
	logic [31:0]  ctrl1;
	logic [31:0]  next_ctrl0;
	logic [31:0]  next_ctrl1;
	prc_wstate_t  wstate;
	prc_wstate_t  next_wstate;
	logic         aw_held;
	logic         w_held;
	logic         next_aw_held;
	logic         next_w_held;
	logic [11:0]  aw_addr;
	logic [11:0]  next_aw_addr;
	logic [31:0]  w_data;
	logic [31:0]  next_w_data;
	logic [3:0]   w_strb;
	logic [3:0]   next_w_strb;
	logic [1:0]   bresp;
	logic [1:0]   next_bresp;
	logic         rvalid;
	logic         next_rvalid;
	logic [31:0]  rdata;
	logic [31:0]  next_rdata;
	logic [1:0]   rresp;
	logic [1:0]   next_rresp;
	logic [31:0]  en0;
	logic [31:0]  en1;
	logic         do_write;

	assign s_axi_awready = (wstate == PRC_W_IDLE) && !aw_held;
	assign s_axi_wready  = (wstate == PRC_W_IDLE) && !w_held;
	assign s_axi_bvalid  = (wstate == PRC_W_RESP);
	assign s_axi_bresp   = bresp;
	assign s_axi_arready = !rvalid;
	assign s_axi_rvalid  = rvalid;
	assign s_axi_rdata   = rdata;
	assign s_axi_rresp   = rresp;

	// ==========================================================
	// Write channel
	always_comb begin
		next_wstate  = wstate;
		next_aw_held = aw_held;
		next_w_held  = w_held;
		next_aw_addr = aw_addr;
		next_w_data  = w_data;
		next_w_strb  = w_strb;
		next_bresp   = bresp;
		do_write     = 1'b0;
		case (wstate)
			PRC_W_IDLE: begin
				if (s_axi_awvalid && s_axi_awready) begin
					next_aw_held = 1'b1;
					next_aw_addr = s_axi_awaddr;
				end
				if (s_axi_wvalid && s_axi_wready) begin
					next_w_held = 1'b1;
					next_w_data = s_axi_wdata;
					next_w_strb = s_axi_wstrb;
				end
				// Both halves held: commit one cycle after the later one
				if (aw_held && w_held) begin
					do_write     = 1'b1;
					next_aw_held = 1'b0;
					next_w_held  = 1'b0;
					next_wstate  = PRC_W_RESP;
					if (aw_addr == `PRC_OFS_CTRL0 || aw_addr == `PRC_OFS_CTRL1) begin
						next_bresp = `PRC_RESP_OKAY;
					end else begin
						next_bresp = `PRC_RESP_SLVERR;
					end
				end
			end
			PRC_W_RESP: begin
				if (s_axi_bready) begin
					next_wstate = PRC_W_IDLE;
				end
			end
			default: next_wstate = PRC_W_IDLE;
		endcase
	end

	// ==========================================================
	// Reset control registers
	always_comb begin
		next_ctrl0 = ctrl0;
		next_ctrl1 = ctrl1;
		en0 = strb_mask(w_strb) & capability_mask_first & `PRC_IMPL0;
		en1 = strb_mask(w_strb) & capability_mask_second & `PRC_IMPL1;
		if (do_write) begin
			if (aw_addr == `PRC_OFS_CTRL0) begin
				next_ctrl0 = merge_write(ctrl0, w_data, en0);
			end else if (aw_addr == `PRC_OFS_CTRL1) begin
				next_ctrl1 = merge_write(ctrl1, w_data, en1);
			end
		end
	end

	// ==========================================================
	// Read channel
	always_comb begin
		next_rvalid = rvalid;
		next_rdata  = rdata;
		next_rresp  = rresp;
		if (rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
		if (s_axi_arvalid && !rvalid) begin
			next_rvalid = 1'b1;
			if (s_axi_araddr == `PRC_OFS_CTRL0) begin
				next_rdata = ctrl0;
				next_rresp = `PRC_RESP_OKAY;
			end else if (s_axi_araddr == `PRC_OFS_CTRL1) begin
				next_rdata = ctrl1;
				next_rresp = `PRC_RESP_OKAY;
			end else begin
				next_rdata = `PRC_RST_VAL;
				next_rresp = `PRC_RESP_SLVERR;
			end
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ctrl0   <= `PRC_RST_VAL;
			ctrl1   <= `PRC_RST_VAL;
			wstate  <= PRC_W_IDLE;
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= '0;
			w_data  <= `PRC_RST_VAL;
			w_strb  <= 4'h0;
			bresp   <= `PRC_RESP_OKAY;
			rvalid  <= 1'b0;
			rdata   <= `PRC_RST_VAL;
			rresp   <= `PRC_RESP_OKAY;
		end else begin
			ctrl0   <= next_ctrl0;
			ctrl1   <= next_ctrl1;
			wstate  <= next_wstate;
			aw_held <= next_aw_held;
			w_held  <= next_w_held;
			aw_addr <= next_aw_addr;
			w_data  <= next_w_data;
			w_strb  <= next_w_strb;
			bresp   <= next_bresp;
			rvalid  <= next_rvalid;
			rdata   <= next_rdata;
			rresp   <= next_rresp;
		end
	end

	// ==========================================================
	// Reset outputs, straight from flip-flops so no glitch reaches a unit
	always_comb begin
		periph_reset.adc0         = ctrl0[`PRC_B_ADC0];
		periph_reset.hibernation  = ctrl0[`PRC_B_HIBERNATE];
		periph_reset.watchdog     = ctrl0[`PRC_B_WATCHDOG];
		periph_reset.comparator   = {ctrl1[`PRC_B_CMP1], ctrl1[`PRC_B_CMP0]};
		periph_reset.gp_counter   = ctrl1[`PRC_B_TMR_HI:`PRC_B_TMR_LO];
		periph_reset.two_wire     = {ctrl1[`PRC_B_TW1], ctrl1[`PRC_B_TW0]};
		periph_reset.sync_serial  = {ctrl1[`PRC_B_SS1], ctrl1[`PRC_B_SS0]};
		periph_reset.async_serial = {ctrl1[`PRC_B_AS1], ctrl1[`PRC_B_AS0]};
	end

	// ==========================================================
	// Checks
	sequence s_wr0_commit;
		do_write && aw_addr == `PRC_OFS_CTRL0;
	endsequence
	sequence s_wr1_commit;
		do_write && aw_addr == `PRC_OFS_CTRL1;
	endsequence

	a_mask_first: assert property (@(posedge clk) disable iff (sys_rst)
		s_wr0_commit |=> ((ctrl0 ^ $past(ctrl0)) & ~$past(en0)) == 32'h0000_0000)
		else $error("first register changed outside capability mask");
	a_mask_second: assert property (@(posedge clk) disable iff (sys_rst)
		(do_write && aw_addr == `PRC_OFS_CTRL1) |=> ((ctrl1 ^ $past(ctrl1)) & ~$past(en1)) == 32'h0000_0000)
		else $error("second register changed outside capability mask");
	a_adc_follow: assert property (@(posedge clk) disable iff (sys_rst)
		(s_wr0_commit ##0 en0[`PRC_B_ADC0])
		|=> periph_reset.adc0 == $past(w_data[`PRC_B_ADC0]))
		else $error("converter reset not following its written bit");
	a_hibernate_follow: assert property (@(posedge clk) disable iff (sys_rst)
		(s_wr0_commit ##0 en0[`PRC_B_HIBERNATE])
		|=> periph_reset.hibernation == $past(w_data[`PRC_B_HIBERNATE]))
		else $error("hibernation reset not following its written bit");
	a_comp_follow: assert property (@(posedge clk) disable iff (sys_rst)
		(s_wr1_commit ##0 (en1[`PRC_B_CMP1] && en1[`PRC_B_CMP0]))
		|=> periph_reset.comparator == {$past(w_data[`PRC_B_CMP1]), $past(w_data[`PRC_B_CMP0])})
		else $error("comparator resets not following written bits");
	a_gp_follow: assert property (@(posedge clk) disable iff (sys_rst)
		(s_wr1_commit ##0 (&en1[`PRC_B_TMR_HI:`PRC_B_TMR_LO]))
		|=> periph_reset.gp_counter == $past(w_data[`PRC_B_TMR_HI:`PRC_B_TMR_LO]))
		else $error("counter resets not following written bits");
	a_two_wire_follow: assert property (@(posedge clk) disable iff (sys_rst)
		(s_wr1_commit ##0 (en1[`PRC_B_TW1] && en1[`PRC_B_TW0]))
		|=> periph_reset.two_wire == {$past(w_data[`PRC_B_TW1]), $past(w_data[`PRC_B_TW0])})
		else $error("two-wire resets not following written bits");
	a_sync_follow: assert property (@(posedge clk) disable iff (sys_rst)
		(s_wr1_commit ##0 (en1[`PRC_B_SS1] && en1[`PRC_B_SS0]))
		|=> periph_reset.sync_serial == {$past(w_data[`PRC_B_SS1]), $past(w_data[`PRC_B_SS0])})
		else $error("sync serial resets not following written bits");
	a_async_follow: assert property (@(posedge clk) disable iff (sys_rst)
		(s_wr1_commit ##0 (en1[`PRC_B_AS1] && en1[`PRC_B_AS0]))
		|=> periph_reset.async_serial == {$past(w_data[`PRC_B_AS1]), $past(w_data[`PRC_B_AS0])})
		else $error("async serial resets not following written bits");
	a_reserved_zero: assert property (@(posedge clk) disable iff (sys_rst)
		((ctrl0 & ~`PRC_IMPL0) == 32'h0000_0000) && ((ctrl1 & ~`PRC_IMPL1) == 32'h0000_0000))
		else $error("unassigned bit set");
	a_reset_clear: assert property (@(posedge clk)
		sys_rst |=> (ctrl0 == `PRC_RST_VAL) && (ctrl1 == `PRC_RST_VAL))
		else $error("registers not cleared by reset");
	a_watchdog_hold: assert property (@(posedge clk) disable iff (sys_rst)
		(periph_reset.watchdog && !do_write) |=> periph_reset.watchdog)
		else $error("watchdog reset dropped without a write");
	a_watchdog_release: assert property (@(posedge clk) disable iff (sys_rst)
		(s_wr0_commit ##0 (en0[`PRC_B_WATCHDOG] && !w_data[`PRC_B_WATCHDOG]))
		|=> !periph_reset.watchdog)
		else $error("watchdog reset not released by clearing write");
	a_idle_stable: assert property (@(posedge clk) disable iff (sys_rst)
		!do_write |=> $stable(ctrl0) && $stable(ctrl1))
		else $error("control register changed without a write");
	a_absent_zero: assert property (@(posedge clk) disable iff (sys_rst)
		(!capability_mask_second[`PRC_B_AS1] && !ctrl1[`PRC_B_AS1] && $stable(capability_mask_second))
		|=> !ctrl1[`PRC_B_AS1])
		else $error("absent serial port bit became set");
	a_read_back: assert property (@(posedge clk) disable iff (sys_rst)
		(s_axi_arvalid && s_axi_arready && s_axi_araddr == `PRC_OFS_CTRL1)
		|=> s_axi_rvalid && s_axi_rdata[`PRC_B_CMP1] == $past(ctrl1[`PRC_B_CMP1]))
		else $error("read of second register wrong");

endmodule

`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the peripheral soft reset registers over AXI4-Lite.
// Assumes prc_pkg and prc_soft_reset are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
`include "prc_params.svh"

module tb_top;
	import prc_pkg::*;
	// ==========================================================
	// Signals
	logic        clk     = 1'b0;
	logic        sys_rst = 1'b1;
	logic [31:0] cap0    = 32'hFFFF_FFFF;
	logic [31:0] cap1    = 32'hFFFF_FFFF;
	logic [11:0] awaddr  = 12'h000;
	logic        awvalid = 1'b0;
	logic        awready;
	logic [31:0] wdata   = 32'h0000_0000;
	logic [3:0]  wstrb   = 4'hF;
	logic        wvalid  = 1'b0;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready  = 1'b0;
	logic [11:0] araddr  = 12'h000;
	logic        arvalid = 1'b0;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready  = 1'b0;
	prc_resets_t periph_reset;
	int          fails   = 0;
	int          checked = 0;
	logic [31:0] s0      = 32'h0000_0000;
	logic [31:0] s1      = 32'h0000_0000;

	prc_soft_reset prc_soft_reset_inst (
		.clk(clk), .sys_rst(sys_rst),
		.capability_mask_first(cap0), .capability_mask_second(cap1),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.periph_reset(periph_reset)
	);

	always #12.5 clk = ~clk;

	// ==========================================================
	// Helpers
	task automatic test_done;
		if (fails == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Reset outputs in struct order, taken straight from the bit map
	function automatic logic [31:0] pr_exp(input logic [31:0] r0, input logic [31:0] r1);
		return {17'h0, r0[16], r0[6], r0[3], r1[25:24], r1[19:16], r1[14], r1[12], r1[5:4], r1[1:0]};
	endfunction

	// Address and data offered together; each released once taken
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
		logic ad;
		logic wd;
		ad = 1'b0;
		wd = 1'b0;
		@(posedge clk);
		awaddr  <= a;
		awvalid <= 1'b1;
		wdata   <= d;
		wstrb   <= s;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge clk);
			if (!ad && awready === 1'b1) begin
				ad = 1'b1;
				awvalid <= 1'b0;
			end
			if (!wd && wready === 1'b1) begin
				wd = 1'b1;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1) @(posedge clk);
		bready <= 1'b0;
		chk({30'h0, bresp}, {30'h0, er});
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk); while (rvalid !== 1'b1);
		rready <= 1'b0;
		chk(rdata, ed);
		chk({30'h0, rresp}, {30'h0, er});
	endtask

	// Write, read back, then compare the reset outputs with the shadow copy
	task automatic wr_rd(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [31:0] e);
		wr(a, d, s, `PRC_RESP_OKAY);
		rd(a, e, `PRC_RESP_OKAY);
		if (a == `PRC_OFS_CTRL0) s0 = e;
		else s1 = e;
		chk({17'h0, periph_reset}, pr_exp(s0, s1));
	endtask

	// ==========================================================
	// Tests
	initial begin
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		rd(`PRC_OFS_CTRL0, 32'h0, `PRC_RESP_OKAY);
		rd(`PRC_OFS_CTRL1, 32'h0, `PRC_RESP_OKAY);
		chk({17'h0, periph_reset}, 32'h0);
		// Walking one over every bit of both registers
		for (int i = 0; i < 32; i++) begin
			wr_rd(`PRC_OFS_CTRL0, 32'h1 << i, 4'hF, (32'h1 << i) & `PRC_IMPL0);
			wr_rd(`PRC_OFS_CTRL1, 32'h1 << i, 4'hF, (32'h1 << i) & `PRC_IMPL1);
		end
		wr_rd(`PRC_OFS_CTRL0, 32'hFFFF_FFFF, 4'hF, `PRC_IMPL0);
		wr_rd(`PRC_OFS_CTRL1, 32'hFFFF_FFFF, 4'hF, `PRC_IMPL1);
		chk({17'h0, periph_reset}, 32'h0000_7FFF);
		// Masked bit keeps its value whichever way the write goes
		cap0 <= 32'hFFFF_FFF7;
		wr_rd(`PRC_OFS_CTRL0, 32'h0, 4'hF, 32'h0000_0008);
		cap1 <= 32'h0000_0001;
		wr_rd(`PRC_OFS_CTRL1, 32'h0, 4'hF, 32'h030F_5032);
		cap0 <= 32'hFFFF_FFFF;
		cap1 <= 32'hFFFF_FFFF;
		wr_rd(`PRC_OFS_CTRL0, 32'h0, 4'hF, 32'h0);
		wr_rd(`PRC_OFS_CTRL1, 32'h0, 4'hF, 32'h0);
		cap0 <= 32'hFFFF_FFF7;
		cap1 <= 32'h0000_0001;
		wr_rd(`PRC_OFS_CTRL0, 32'hFFFF_FFFF, 4'hF, 32'h0001_0040);
		wr_rd(`PRC_OFS_CTRL1, 32'hFFFF_FFFF, 4'hF, 32'h0000_0001);
		cap0 <= 32'hFFFF_FFFF;
		cap1 <= 32'hFFFF_FFFF;
		// Byte lanes honoured: lane 2 alone, then lanes 0, 1 and 3 together
		wr_rd(`PRC_OFS_CTRL0, 32'h0, 4'hF, 32'h0);
		wr_rd(`PRC_OFS_CTRL0, 32'hFFFF_FFFF, 4'h4, 32'h0001_0000);
		wr_rd(`PRC_OFS_CTRL0, 32'hFFFF_FFFF, 4'hB, 32'h0001_0048);
		// Unmapped place refused without side effect
		wr(12'h048, 32'hFFFF_FFFF, 4'hF, `PRC_RESP_SLVERR);
		rd(12'h048, 32'h0, `PRC_RESP_SLVERR);
		rd(`PRC_OFS_CTRL0, 32'h0001_0048, `PRC_RESP_OKAY);
		// Reset in mid-run clears everything
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		rd(`PRC_OFS_CTRL0, 32'h0, `PRC_RESP_OKAY);
		rd(`PRC_OFS_CTRL1, 32'h0, `PRC_RESP_OKAY);
		chk({17'h0, periph_reset}, 32'h0);
		test_done();
	end

	// Run needs well under 2000 cycles
	initial begin
		repeat (5000) @(posedge clk);
		fails++;
		test_done();
	end
endmodule

`default_nettype wire
